/* File: rtl/dbgx_pkg.sv */
/*
 * Shared constants and types of the debug exception unit.
 * Assumes a 32-bit linear address space and four breakpoint slots.
 */
`default_nettype none

package dbgx_pkg;

    // ----------------------------------------------------------------
    // Sizes and vector
    // ----------------------------------------------------------------
    localparam int          NUM_BP     = 4;
    localparam int          ADDR_W     = 32;
    localparam logic [7:0]  DBG_VECTOR = 8'h01;

    // ----------------------------------------------------------------
    // Breakpoint condition and length codes
    // ----------------------------------------------------------------
    localparam logic [1:0]  COND_EXEC  = 2'h0;
    localparam logic [1:0]  COND_WRITE = 2'h1;
    localparam logic [1:0]  COND_IO    = 2'h2;
    localparam logic [1:0]  COND_RDWR  = 2'h3;
    localparam logic [1:0]  LEN_1      = 2'h0;
    localparam logic [1:0]  LEN_2      = 2'h1;
    localparam logic [1:0]  LEN_4      = 2'h3;
    localparam logic [3:0]  MASK_1     = 4'h1;
    localparam logic [3:0]  MASK_2     = 4'h3;
    localparam logic [3:0]  MASK_4     = 4'hf;

    // ----------------------------------------------------------------
    // Retire kinds reported by the pipeline
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        RK_NORMAL = 3'h0,
        RK_POP_FLAGS_INSTR   = 3'h1,
        RK_IRETW  = 3'h3,
        RK_INTERRUPT_RETURN_DWORD  = 3'h2,
        RK_TASK   = 3'h6,
        RK_SWINT  = 3'h7
    } dbgx_retire_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic              enable;
        logic [1:0]        cond;
        logic [1:0]        len;
        logic [ADDR_W-1:0] addr;
    } dbgx_bp_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic              io;
        logic [1:0]        len;
        logic [ADDR_W-1:0] addr;
    } dbgx_access_t;

    typedef struct packed {
        logic              single_step;
        logic              protect_detect;
        logic              task_switch;
        logic [NUM_BP-1:0] hit;
    } dbgx_status_t;

    typedef struct packed {
        logic fault;
        logic trap;
    } dbgx_class_t;

    localparam dbgx_status_t STATUS_RESET = '0;

endpackage

`default_nettype wire

/* File: rtl/dbgx_unit.sv */
/*
 * Debug exception unit: breakpoint match, fault/trap classing, status,
 * resume flag, trap flag and register protection.
 * Assumes the pipeline reports boundaries, accesses and retirements on
 * the same clock, and never a boundary and a retire in one cycle.
 */
`default_nettype none

// Function
// - Every debug condition goes out through vector 1.
// - Instruction breakpoint and protection are faults; all others traps.
// - One exception may carry fault and trap causes together.
// - Instruction breakpoint when fetch address equals an exec slot.
// - Instruction breakpoint fault is raised before the instruction runs.
// - Instruction breakpoint beats every other exception of that instr.
// - Resume flag set blocks instruction breakpoint detection.
// - Non-breakpoint fault entry sets the resume flag.
// - Doubleword return and task switch load resume flag from image.
// - Resume flag does not block data, I/O or other exceptions.
// - Successful retire clears resume flag, except dword return, task.
// - Trap and interrupt entries leave the resume flag alone.
// - Data and I/O breakpoints trap after the access completes.
// - Repeated port strings trap after the matching iteration.
// - Protected debug register move faults first, sets detect flag.
// - Trap flag set before an instruction gives a step trap after it.
// - Trap flag is cleared on entry to the step handler.
// - Trap flag loaded at task switch steps after first new instr.
// - Privilege change keeps trap flag; software interrupts clear it.
// - Step trap goes first; pending interrupt sampled after entry.
// - Task-trap bit of new task traps before its first instruction.
// - Debug handler entry clears the register protection enable.
// - Data breakpoint hits if any accessed byte is in range.

module dbgx_unit
    import dbgx_pkg::*;
#(
    parameter int BP_COUNT = NUM_BP
) (
    // Clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_rstn,
    // Breakpoint setup
    input  wire dbgx_bp_t     i_bp [NUM_BP],
    // Instruction boundary
    input  wire logic         i_boundary,
    input  wire logic [31:0]  i_instr_addr,
    input  wire logic         i_mov_dbg,
    input  wire logic         i_other_fault,
    // Data and port accesses
    input  wire dbgx_access_t i_access,
    input  wire logic         i_iter_done,
    // Retirement
    input  wire logic         i_retire,
    input  wire dbgx_retire_t i_retire_kind,
    input  wire logic         i_image_rf,
    input  wire logic         i_image_tf,
    input  wire logic         i_task_trap,
    // Software control
    input  wire logic         i_protect_wr,
    input  wire logic         i_protect_val,
    input  wire logic         i_status_clear,
    // Exception request
    output logic              o_cancel,
    output logic              o_exc_valid,
    output logic [7:0]        o_exc_vector,
    output dbgx_class_t       o_exc_class,
    // Interrupt ordering
    output logic              o_irq_hold,
    output logic              o_irq_sample,
    // State
    output dbgx_status_t      o_status,
    output logic              o_resume_flag,
    output logic              o_trap_flag,
    output logic              o_protect_en
);

    if (BP_COUNT < 1 || BP_COUNT > NUM_BP) begin : g_chk
        $error("BP_COUNT out of range");
    end

    // ----------------------------------------------------------------
    // Match functions
    // ----------------------------------------------------------------
    function automatic logic [3:0] len_mask(input logic [1:0] len);
        unique case (len)
            LEN_2:   return MASK_2;
            LEN_4:   return MASK_4;
            default: return MASK_1;
        endcase
    endfunction

    function automatic logic overlap(input dbgx_bp_t bp,
                                     input dbgx_access_t ac);
        logic [3:0]  m;
        logic [1:0]  lo;
        logic [3:0]  bm;
        logic [7:0]  am;
        logic [29:0] nxt;
        m   = len_mask(bp.len);
        lo  = bp.addr[1:0] & ~{m[3], m[1]};
        bm  = m << lo;
        am  = {4'h0, len_mask(ac.len)} << ac.addr[1:0];
        nxt = ac.addr[31:2] + 30'h1;
        return (bp.addr[31:2] == ac.addr[31:2] && |(bm & am[3:0])) ||
               (bp.addr[31:2] == nxt && |(bm & am[7:4]));
    endfunction

    function automatic logic cond_ok(input logic [1:0] c,
                                     input dbgx_access_t ac);
        unique case (c)
            COND_WRITE: return !ac.io && ac.write;
            COND_IO:    return ac.io;
            COND_RDWR:  return !ac.io;
            default:    return 1'b0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic              rf;
    logic              tf;
    logic              gd;
    dbgx_status_t      status;
    logic              pend_step;
    logic              pend_task;
    logic [NUM_BP-1:0] pend_hit;
    logic [NUM_BP-1:0] acc_hit;
    logic [NUM_BP-1:0] ibp_hit;
    logic [NUM_BP-1:0] dbp_hit;

    // ----------------------------------------------------------------
    // Per-slot detection
    // ----------------------------------------------------------------
    for (genvar n = 0; n < NUM_BP; n++) begin : g_bp
        wire logic live = (n < BP_COUNT) && i_bp[n].enable;
        assign ibp_hit[n] = i_boundary && !rf && live &&
                            i_bp[n].cond == COND_EXEC &&
                            i_bp[n].addr == i_instr_addr;
        // byte range overlap, resume flag ignored
        assign dbp_hit[n] = i_access.valid && live &&
                            cond_ok(i_bp[n].cond, i_access) &&
                            overlap(i_bp[n], i_access);
    end

    // ----------------------------------------------------------------
    // Boundary decisions
    // ----------------------------------------------------------------
    wire logic ibp_any   = |ibp_hit;
    wire logic gd_hit    = i_boundary && gd && i_mov_dbg;
    wire logic trap_any  = pend_step || pend_task || (|pend_hit);
    wire logic fault_any = ibp_any || gd_hit;
    // debug entry cancels the instruction and any other fault
    wire logic take      = i_boundary && (fault_any || trap_any);
    wire logic oth_entry = i_boundary && i_other_fault && !take;
    wire logic cap       = i_retire || i_iter_done;
    wire logic ld_img    = i_retire_kind == RK_INTERRUPT_RETURN_DWORD ||
                           i_retire_kind == RK_TASK;
    wire logic ld_tf     = ld_img || i_retire_kind == RK_POP_FLAGS_INSTR ||
                           i_retire_kind == RK_IRETW;

    assign o_cancel   = take;
    // interrupt waits behind a pending step trap
    assign o_irq_hold = pend_step;

    // ----------------------------------------------------------------
    // Next values
    // ----------------------------------------------------------------
    dbgx_status_t      next_status;
    logic              next_rf;
    logic              next_tf;
    logic              next_gd;

    always_comb begin
        next_status = i_status_clear ? STATUS_RESET : status;
        // every cause recorded at once; set wins
        if (take) begin
            next_status.single_step    = next_status.single_step ||
                                         pend_step;
            next_status.task_switch    = next_status.task_switch ||
                                         pend_task;
            next_status.protect_detect = next_status.protect_detect ||
                                         gd_hit;
            next_status.hit = next_status.hit | pend_hit | ibp_hit;
        end
    end

    always_comb begin
        next_rf = rf;
        if (i_retire) begin
            // image load or clear on retire
            next_rf = ld_img ? i_image_rf : 1'b0;
        end else if ((take && gd_hit && !ibp_any) || oth_entry) begin
            // only non-breakpoint fault entries set it
            next_rf = 1'b1;
        end
    end

    always_comb begin
        next_tf = tf;
        if (i_retire) begin
            // software interrupts clear, loads follow the image
            if (i_retire_kind == RK_SWINT) begin
                next_tf = 1'b0;
            end else if (ld_tf) begin
                next_tf = i_image_tf;
            end
        end else if (take && pend_step) begin
            // step handler runs with the flag clear
            next_tf = 1'b0;
        end
    end

    always_comb begin
        next_gd = gd;
        if (i_protect_wr) begin
            next_gd = i_protect_val;
        end
        // entry clears protection, beating a same-cycle write
        if (take) begin
            next_gd = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Flags and status
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            rf     <= 1'b0;
            tf     <= 1'b0;
            gd     <= 1'b0;
            status <= STATUS_RESET;
        end else begin
            rf     <= next_rf;
            tf     <= next_tf;
            gd     <= next_gd;
            status <= next_status;
        end
    end

    // ----------------------------------------------------------------
    // Pending traps
    // ----------------------------------------------------------------
    // Traps wait for the next boundary so they merge with its faults.
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            pend_step <= 1'b0;
            pend_task <= 1'b0;
            pend_hit  <= '0;
            acc_hit   <= '0;
        end else if (take) begin
            pend_step <= 1'b0;
            pend_task <= 1'b0;
            pend_hit  <= '0;
            acc_hit   <= acc_hit | dbp_hit;
        end else if (cap) begin
            // trap after access or matching iteration
            pend_hit  <= pend_hit | acc_hit | dbp_hit;
            acc_hit   <= '0;
            if (i_retire) begin
                // old flag value, so the setter never traps
                pend_step <= tf;
                // task trap bit of incoming task
                pend_task <= i_retire_kind == RK_TASK && i_task_trap;
            end
        end else begin
            acc_hit   <= acc_hit | dbp_hit;
        end
    end

    // ----------------------------------------------------------------
    // Exception outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            o_exc_valid  <= 1'b0;
            o_exc_vector <= 8'h00;
            o_exc_class  <= '0;
            o_irq_sample <= 1'b0;
        end else begin
            o_exc_valid  <= take;
            o_exc_vector <= take ? DBG_VECTOR : 8'h00;
            o_exc_class  <= take ? {fault_any, trap_any} : 2'h0;
            // interrupt examined before handler's first instr
            o_irq_sample <= take && pend_step;
        end
    end

    assign o_status      = status;
    assign o_resume_flag = rf;
    assign o_trap_flag   = tf;
    assign o_protect_en  = gd;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    property p_vector;
        o_exc_valid |-> o_exc_vector == DBG_VECTOR;
    endproperty
    a_vector: assert property (p_vector)
        else $error("debug vector wrong");

    property p_ibp_fault;
        i_boundary && ibp_any |-> o_cancel ##1 o_exc_class.fault;
    endproperty
    a_ibp_fault: assert property (p_ibp_fault)
        else $error("breakpoint not a fault");

    property p_both;
        take && gd_hit && trap_any |=> o_exc_class == 2'h3;
    endproperty
    a_both: assert property (p_both)
        else $error("fault and trap not merged");

    property p_rf_block;
        rf && i_boundary && !gd_hit && !trap_any |-> !o_cancel;
    endproperty
    a_rf_block: assert property (p_rf_block)
        else $error("breakpoint seen under resume flag");

    property p_rf_set;
        oth_entry && !i_retire |=> rf;
    endproperty
    a_rf_set: assert property (p_rf_set)
        else $error("resume flag not set on fault");

    property p_rf_load;
        i_retire && ld_img |=> rf == $past(i_image_rf);
    endproperty
    a_rf_load: assert property (p_rf_load)
        else $error("resume flag not loaded");

    property p_rf_clear;
        i_retire && !ld_img |=> !rf;
    endproperty
    a_rf_clear: assert property (p_rf_clear)
        else $error("resume flag not cleared");

    property p_trap_keep;
        take && !fault_any && !i_retire |=> rf == $past(rf);
    endproperty
    a_trap_keep: assert property (p_trap_keep)
        else $error("trap entry changed resume flag");

    property p_gd;
        gd_hit |=> o_exc_valid && status.protect_detect && !gd;
    endproperty
    a_gd: assert property (p_gd)
        else $error("protection fault lost");

    property p_step;
        i_retire && !take |=> pend_step == $past(tf);
    endproperty
    a_step: assert property (p_step)
        else $error("step pending wrong");

    property p_step_entry;
        take && pend_step |=> !tf && status.single_step && o_irq_sample;
    endproperty
    a_step_entry: assert property (p_step_entry)
        else $error("step entry wrong");

    c_ibp:  cover property (i_boundary && ibp_any);
    c_data: cover property (take && |pend_hit);
    c_step: cover property (take && pend_step ##1 o_irq_sample);
    c_task: cover property (take && pend_task && gd_hit);

endmodule

`default_nettype wire

/* File: test/dbgx_irq_model.sv */
/*
 * External interrupt logic model facing the debug exception unit.
 * Assumes requests arrive as one-cycle pulses, one pending at a time.
 */
`default_nettype none

module dbgx_irq_model (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_rstn,
    // Request and ordering
    input  wire logic i_irq,
    input  wire logic i_irq_hold,
    // Service record, sticky so the bench can look late
    output logic      o_served
);
    timeunit 1ns;
    timeprecision 1ps;

    logic pending;

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            pending  <= 1'h0;
            o_served <= 1'h0;
        end else if (i_irq) begin
            pending <= 1'h1;
        end else if (pending && !i_irq_hold) begin
            pending  <= 1'h0;
            o_served <= 1'h1;
        end
    end
endmodule

`default_nettype wire

/* File: test/dbgx_unit_test.sv */
/*
 * Self-checking bench of the debug exception unit.
 * Assumes the unit, its package and the interrupt logic model.
 */
`default_nettype none

module dbgx_unit_test;
    import dbgx_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic         i_clock;
    logic         i_rstn;
    dbgx_bp_t     i_bp [NUM_BP];
    logic         i_boundary;
    logic [31:0]  i_instr_addr;
    logic         i_mov_dbg;
    logic         i_other_fault;
    dbgx_access_t i_access;
    logic         i_iter_done;
    logic         i_retire;
    dbgx_retire_t i_retire_kind;
    logic         i_image_rf;
    logic         i_image_tf;
    logic         i_task_trap;
    logic         i_protect_wr;
    logic         i_protect_val;
    logic         i_status_clear;
    logic         o_cancel;
    logic         o_exc_valid;
    logic [7:0]   o_exc_vector;
    dbgx_class_t  o_exc_class;
    logic         o_irq_hold;
    logic         o_irq_sample;
    dbgx_status_t o_status;
    logic         o_resume_flag;
    logic         o_trap_flag;
    logic         o_protect_en;
    logic         irq;
    logic         served;
    int           failures;
    int           checks;

    dbgx_unit dbgx_unit_inst (
        .i_clock, .i_rstn, .i_bp, .i_boundary, .i_instr_addr, .i_mov_dbg,
        .i_other_fault, .i_access, .i_iter_done, .i_retire, .i_retire_kind,
        .i_image_rf, .i_image_tf, .i_task_trap, .i_protect_wr,
        .i_protect_val, .i_status_clear, .o_cancel, .o_exc_valid,
        .o_exc_vector, .o_exc_class, .o_irq_hold, .o_irq_sample, .o_status,
        .o_resume_flag, .o_trap_flag, .o_protect_en
    );

    dbgx_irq_model dbgx_irq_model_inst (
        .i_clock, .i_rstn, .i_irq(irq), .i_irq_hold(o_irq_hold),
        .o_served(served)
    );

    initial begin
        i_clock = 1'h0;
        forever #4 i_clock = ~i_clock;
    end

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t: got %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (failures == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One instruction boundary; cancel now, exception report next cycle
    task automatic bnd(input logic [31:0] a, input logic mv, input logic of,
                       input logic c, input logic [1:0] cl,
                       input logic [6:0] st);
        @(posedge i_clock);
        i_boundary    <= 1'h1;
        i_instr_addr  <= a;
        i_mov_dbg     <= mv;
        i_other_fault <= of;
        @(negedge i_clock);
        chk(16'(o_cancel), 16'(c));
        @(posedge i_clock);
        i_boundary    <= 1'h0;
        i_mov_dbg     <= 1'h0;
        i_other_fault <= 1'h0;
        @(negedge i_clock);
        chk(16'({o_exc_valid, o_exc_vector, o_exc_class}),
            16'({c, (c ? DBG_VECTOR : 8'h00), cl}));
        chk(16'(o_status), 16'(st));
    endtask

    task automatic ret(input dbgx_retire_t k, input logic rf, input logic tf,
                       input logic tt);
        @(posedge i_clock);
        i_retire      <= 1'h1;
        i_retire_kind <= k;
        i_image_rf    <= rf;
        i_image_tf    <= tf;
        i_task_trap   <= tt;
        @(posedge i_clock);
        i_retire <= 1'h0;
        @(negedge i_clock);
    endtask

    task automatic acc(input logic w, input logic io, input logic [1:0] ln,
                       input logic [31:0] a);
        @(posedge i_clock);
        i_access <= '{1'h1, w, io, ln, a};
        @(posedge i_clock);
        i_access <= '0;
    endtask

    task automatic prot(input logic v);
        @(posedge i_clock);
        i_protect_wr  <= 1'h1;
        i_protect_val <= v;
        @(posedge i_clock);
        i_protect_wr <= 1'h0;
        @(negedge i_clock);
        chk(16'(o_protect_en), 16'(v));
    endtask

    task automatic clr();
        @(posedge i_clock);
        i_status_clear <= 1'h1;
        @(posedge i_clock);
        i_status_clear <= 1'h0;
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        failures = 0;
        checks = 0;
        i_rstn = 1'h0;
        i_boundary = 1'h0;
        i_instr_addr = 32'h0;
        i_mov_dbg = 1'h0;
        i_other_fault = 1'h0;
        i_access = '0;
        i_iter_done = 1'h0;
        i_retire = 1'h0;
        i_retire_kind = RK_NORMAL;
        i_image_rf = 1'h0;
        i_image_tf = 1'h0;
        i_task_trap = 1'h0;
        i_protect_wr = 1'h0;
        i_protect_val = 1'h0;
        i_status_clear = 1'h0;
        irq = 1'h0;
        i_bp[0] = '{1'h1, COND_EXEC, LEN_1, 32'h0000_1000};
        i_bp[1] = '{1'h1, COND_WRITE, LEN_1, 32'h0000_2002};
        i_bp[2] = '{1'h1, COND_RDWR, LEN_4, 32'h0000_4000};
        i_bp[3] = '{1'h1, COND_IO, LEN_1, 32'h0000_0060};
        repeat (16) @(posedge i_clock);
        @(negedge i_clock);
        chk(16'({o_status, o_resume_flag, o_trap_flag, o_protect_en}),
            16'h0);
        @(posedge i_clock);
        i_rstn <= 1'h1;
        bnd(32'h1004, 1'h0, 1'h0, 1'h0, 2'h0, 7'h00);
        bnd(32'h1000, 1'h0, 1'h0, 1'h1, 2'h2, 7'h01);
        chk(16'(o_resume_flag), 16'h0);
        clr();
        ret(RK_INTERRUPT_RETURN_DWORD, 1'h1, 1'h0, 1'h0);
        chk(16'(o_resume_flag), 16'h1);
        bnd(32'h1000, 1'h0, 1'h0, 1'h0, 2'h0, 7'h00);
        ret(RK_NORMAL, 1'h0, 1'h0, 1'h0);
        chk(16'(o_resume_flag), 16'h0);
        ret(RK_IRETW, 1'h1, 1'h0, 1'h0);
        chk(16'(o_resume_flag), 16'h0);
        ret(RK_POP_FLAGS_INSTR, 1'h1, 1'h0, 1'h0);
        chk(16'(o_resume_flag), 16'h0);
        bnd(32'h1000, 1'h0, 1'h1, 1'h1, 2'h2, 7'h01);
        chk(16'(o_resume_flag), 16'h0);
        bnd(32'h1008, 1'h0, 1'h1, 1'h0, 2'h0, 7'h01);
        chk(16'(o_resume_flag), 16'h1);
        ret(RK_NORMAL, 1'h0, 1'h0, 1'h0);
        prot(1'h1);
        clr();
        bnd(32'h1010, 1'h1, 1'h0, 1'h1, 2'h2, 7'h20);
        chk(16'({o_protect_en, o_resume_flag}), 16'h1);
        ret(RK_NORMAL, 1'h0, 1'h0, 1'h0);
        bnd(32'h1014, 1'h1, 1'h0, 1'h0, 2'h0, 7'h20);
        clr();
        acc(1'h1, 1'h0, LEN_2, 32'h2001);
        ret(RK_NORMAL, 1'h0, 1'h0, 1'h0);
        bnd(32'h3000, 1'h0, 1'h0, 1'h1, 2'h1, 7'h02);
        chk(16'(o_resume_flag), 16'h0);
        acc(1'h0, 1'h0, LEN_1, 32'h2002);
        ret(RK_NORMAL, 1'h0, 1'h0, 1'h0);
        bnd(32'h3004, 1'h0, 1'h0, 1'h0, 2'h0, 7'h02);
        acc(1'h0, 1'h0, LEN_1, 32'h4003);
        ret(RK_INTERRUPT_RETURN_DWORD, 1'h1, 1'h0, 1'h0);
        bnd(32'h1000, 1'h0, 1'h0, 1'h1, 2'h1, 7'h06);
        chk(16'(o_resume_flag), 16'h1);
        ret(RK_NORMAL, 1'h0, 1'h0, 1'h0);
        clr();
        acc(1'h0, 1'h1, LEN_1, 32'h0060);
        @(posedge i_clock);
        i_iter_done <= 1'h1;
        @(posedge i_clock);
        i_iter_done <= 1'h0;
        bnd(32'h3008, 1'h0, 1'h0, 1'h1, 2'h1, 7'h08);
        clr();
        ret(RK_POP_FLAGS_INSTR, 1'h0, 1'h1, 1'h0);
        chk(16'({o_trap_flag, o_irq_hold}), 16'h2);
        bnd(32'h300c, 1'h0, 1'h0, 1'h0, 2'h0, 7'h00);
        ret(RK_NORMAL, 1'h0, 1'h0, 1'h0);
        chk(16'(o_irq_hold), 16'h1);
        @(posedge i_clock);
        irq <= 1'h1;
        @(posedge i_clock);
        irq <= 1'h0;
        repeat (2) @(negedge i_clock);
        chk(16'(served), 16'h0);
        bnd(32'h3010, 1'h0, 1'h0, 1'h1, 2'h1, 7'h40);
        chk(16'({o_trap_flag, o_irq_sample, o_irq_hold}), 16'h2);
        @(negedge i_clock);
        chk(16'(served), 16'h1);
        clr();
        ret(RK_TASK, 1'h0, 1'h1, 1'h1);
        bnd(32'h5000, 1'h0, 1'h0, 1'h1, 2'h1, 7'h10);
        chk(16'(o_trap_flag), 16'h1);
        bnd(32'h5004, 1'h0, 1'h0, 1'h0, 2'h0, 7'h10);
        ret(RK_NORMAL, 1'h0, 1'h0, 1'h0);
        bnd(32'h5008, 1'h0, 1'h0, 1'h1, 2'h1, 7'h50);
        clr();
        ret(RK_POP_FLAGS_INSTR, 1'h0, 1'h1, 1'h0);
        ret(RK_NORMAL, 1'h0, 1'h0, 1'h0);
        chk(16'(o_trap_flag), 16'h1);
        ret(RK_SWINT, 1'h0, 1'h0, 1'h0);
        chk(16'(o_trap_flag), 16'h0);
        prot(1'h1);
        bnd(32'h6000, 1'h1, 1'h0, 1'h1, 2'h3, 7'h60);
        chk(16'({o_protect_en, o_resume_flag}), 16'h1);
        // handler task entered with its task-trap bit clear
        ret(RK_TASK, 1'h0, 1'h0, 1'h0);
        bnd(32'h7000, 1'h0, 1'h0, 1'h0, 2'h0, 7'h60);
        results();
    end

    // Hang guard, far beyond the roughly 120 cycles the tests need
    initial begin
        repeat (5000) @(posedge i_clock);
        failures++;
        results();
    end
endmodule

`default_nettype wire
